// file: rtl/dewg_pkg.sv
package dewg_pkg;

	// ********************************************
	// register offsets (byte addresses on apb)
	// ********************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_UNLOCK = 8'h04;
	localparam logic [7:0] OFS_ADDR_LO = 8'h08;
	localparam logic [7:0] OFS_ADDR_HI = 8'h0c;
	localparam logic [7:0] OFS_DATA_LO = 8'h10;
	localparam logic [7:0] OFS_DATA_HI = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN = 8'h18;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h1c;

	// ********************************************
	// field positions and implemented-bit masks
	// ********************************************
	localparam int CTL_PGM = 7;
	localparam int CTL_WERR = 3;
	localparam int CTL_WRITE_ENABLE_BIT = 2;
	localparam int CTL_WR = 1;
	localparam int CTL_RD = 0;
	localparam logic [7:0] CTL_MASK = 8'h8e;
	localparam logic [7:0] ADDRH_MASK = 8'h1f;
	localparam logic [7:0] DATAH_MASK = 8'h3f;
	localparam int IRQ_BIT = 4;
	localparam logic [7:0] IRQ_MASK = 8'h10;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [23:0] PRDATA_PAD = 24'h00_0000;

	// ********************************************
	// unlock keys
	// ********************************************
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

	// ********************************************
	// timing
	// ********************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int PWRT_MS = 64;
	localparam int PWRT_CYCLES = PWRT_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int PWRT_CNT_W = 22;
	localparam int WRITE_CYCLES = 8;
	localparam logic [3:0] WCNT_LAST = 4'(WRITE_CYCLES - 1);
	localparam logic [3:0] WCNT_ZERO = 4'h0;
	localparam logic [3:0] WCNT_ONE = 4'h1;

	// ********************************************
	// state encodings
	// ********************************************
	typedef enum logic [2:0] {
		UL_IDLE = 3'b001,
		UL_KEY1 = 3'b010,
		UL_ARMED = 3'b100
	} dewg_unlock_t;

	typedef enum logic [1:0] {
		WS_IDLE = 2'b01,
		WS_BUSY = 2'b10
	} dewg_wstate_t;

endpackage : dewg_pkg

// file: rtl/dewg_pwrt.sv
`timescale 1ns/1ps
module dewg_pwrt #(
	parameter int CYCLES = dewg_pkg::PWRT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic busy
);

	// ********************************************
	// power-up timer state
	// ********************************************
	typedef struct packed {
		logic [dewg_pkg::PWRT_CNT_W-1:0] cnt;
		logic busy;
	} dewg_pwrt_t;

	dewg_pwrt_t r;
	dewg_pwrt_t next_r;

	// count once from power-up, then stay idle until the next reset
	always_comb begin
		next_r = r;
		if (r.busy) begin
			if (r.cnt == dewg_pkg::PWRT_CNT_W'(CYCLES - 1)) begin
				next_r.busy = 1'b0; // [RULE2]
			end else begin
				next_r.cnt = r.cnt + dewg_pkg::PWRT_CNT_W'(1);
			end
		end
	end

	// busy comes up set so writes are blocked from the first edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{cnt: '0, busy: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	assign busy = r.busy;

	property p_pwrt_len;
		@(posedge pclk) disable iff (!presetn)
		$fell(r.busy) |-> $past(r.cnt) == dewg_pkg::PWRT_CNT_W'(CYCLES - 1);
	endproperty
	a_pwrt_len: assert property (p_pwrt_len) // [RULE2]
		else $error("power-up timer ended at the wrong count");

endmodule : dewg_pwrt

// file: rtl/dewg_guard.sv
// Overview of operation
// RULE1: reset clears write enable; no write starts until software sets it.
// RULE2: while the power-up timer runs, every array write start is refused. Programming-path writes are not gated by the timer here.
// RULE3: a write starts only with write enable set and unlock done.
// RULE4: software writes 55h, then AAh, to unlock, then sets write start.
// RULE5: data-protect config bit zero means protected, one unprotected.
// RULE6: while protected, the programming path is denied; the core is not.
// RULE7: software should protect program memory along with data memory.
// RULE8: software verifies each write by reading the address back.
// RULE9: after a write, data low holds the written byte until replaced.
// RULE10: software refreshes the array when rewrites exceed its endurance.
// RULE11: unused bits of control, address and data high read zero.
// RULE12: a finished write sets the done flag; irq follows if enabled.
`timescale 1ns/1ps
module dewg_guard #(
	parameter int PWRT_CYCLES = dewg_pkg::PWRT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic data_protect_config_bit,
	input wire logic ext_prog_req,
	input wire logic ext_prog_write,
	input wire logic [7:0] ext_prog_addr,
	input wire logic [7:0] ext_prog_wdata,
	output logic [7:0] ext_prog_rdata,
	output logic ext_prog_denied,
	output logic ext_prog_ack
);

	// ********************************************
	// state
	// ********************************************
	typedef struct packed {
		logic [1:0] prot_s;
		logic [1:0] req_s;
		logic req_q;
		logic [1:0] we_s;
		logic [7:0] xa0;
		logic [7:0] xa1;
		logic [7:0] xd0;
		logic [7:0] xd1;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic pgm_sel;
		logic werr;
		logic write_enable_bit;
		logic wr;
		dewg_pkg::dewg_unlock_t ul;
		dewg_pkg::dewg_wstate_t ws;
		logic [3:0] wcnt;
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
		logic [7:0] data_lo;
		logic [7:0] data_hi;
		logic [7:0] irq_en;
		logic [7:0] irq_flag;
		logic irq;
		logic [7:0] x_rdata;
		logic x_denied;
		logic x_ack;
		logic [255:0][7:0] mem;
	} dewg_main_t;

	dewg_main_t r;
	dewg_main_t next_r;
	logic pwrt_busy;

	// ********************************************
	// decode helpers
	// ********************************************
	function automatic logic is_mapped(input logic [7:0] a);
		return a == dewg_pkg::OFS_CONTROL || a == dewg_pkg::OFS_UNLOCK ||
			a == dewg_pkg::OFS_ADDR_LO || a == dewg_pkg::OFS_ADDR_HI ||
			a == dewg_pkg::OFS_DATA_LO || a == dewg_pkg::OFS_DATA_HI ||
			a == dewg_pkg::OFS_IRQ_EN || a == dewg_pkg::OFS_IRQ_FLAG;
	endfunction : is_mapped

	// unlock register is not physical and reads zero
	function automatic logic [7:0] rd_mux(input logic [7:0] a,
		input dewg_main_t s);
		logic [7:0] ctl;
		ctl = '0;
		ctl[dewg_pkg::CTL_PGM] = s.pgm_sel;
		ctl[dewg_pkg::CTL_WERR] = s.werr;
		ctl[dewg_pkg::CTL_WRITE_ENABLE_BIT] = s.write_enable_bit;
		ctl[dewg_pkg::CTL_WR] = s.wr;
		case (a)
			dewg_pkg::OFS_CONTROL: return ctl; // [RULE11]
			dewg_pkg::OFS_ADDR_LO: return s.addr_lo;
			dewg_pkg::OFS_ADDR_HI: return s.addr_hi;
			dewg_pkg::OFS_DATA_LO: return s.data_lo;
			dewg_pkg::OFS_DATA_HI: return s.data_hi;
			dewg_pkg::OFS_IRQ_EN: return s.irq_en;
			dewg_pkg::OFS_IRQ_FLAG: return s.irq_flag;
			default: return dewg_pkg::RESET_BYTE;
		endcase
	endfunction : rd_mux

	// ********************************************
	// power-up timer
	// ********************************************
	dewg_pwrt #(
		.CYCLES(PWRT_CYCLES)
	) u_pwrt (
		.pclk(pclk),
		.presetn(presetn),
		.busy(pwrt_busy)
	);

	// ********************************************
	// bus strobes and events
	// ********************************************
	logic acc;
	logic xfer;
	logic wr_any;
	logic wr_ctl;
	logic start_try;
	logic start_ok;
	logic w_done;
	logic ext_go;
	logic prot;

	// one wait state: prdata is latched first, the transfer ends a cycle later
	assign acc = psel & penable;
	assign xfer = acc & r.pready;
	assign wr_any = xfer & pwrite & is_mapped(paddr);
	assign wr_ctl = wr_any & (paddr == dewg_pkg::OFS_CONTROL);
	assign start_try = wr_ctl & pwdata[dewg_pkg::CTL_WR] & ~r.wr;
	assign start_ok = start_try & r.write_enable_bit & // [RULE3]
		(r.ul == dewg_pkg::UL_ARMED) & ~pwrt_busy & // [RULE2]
		~pwdata[dewg_pkg::CTL_PGM] & (r.ws == dewg_pkg::WS_IDLE);
	assign w_done = (r.ws == dewg_pkg::WS_BUSY) & (r.wcnt == dewg_pkg::WCNT_LAST);
	assign ext_go = r.req_s[1] & ~r.req_q;
	assign prot = ~r.prot_s[1]; // [RULE5]

	// ********************************************
	// next state
	// ********************************************
	always_comb begin
		next_r = r;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		next_r.x_ack = 1'b0;
		// pin synchronisers: only the second stage feeds logic
		next_r.prot_s = {r.prot_s[0], data_protect_config_bit};
		next_r.req_s = {r.req_s[0], ext_prog_req};
		next_r.req_q = r.req_s[1];
		next_r.we_s = {r.we_s[0], ext_prog_write};
		next_r.xa0 = ext_prog_addr;
		next_r.xa1 = r.xa0;
		next_r.xd0 = ext_prog_wdata;
		next_r.xd1 = r.xd0;
		// access phase, first cycle: latch read data and the error answer
		if (acc && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.pslverr = ~is_mapped(paddr);
			next_r.prdata = {dewg_pkg::PRDATA_PAD, rd_mux(paddr, r)};
		end
		// read clears only the flag bits actually returned, so later events stay
		if (xfer && !pwrite && paddr == dewg_pkg::OFS_IRQ_FLAG) begin
			next_r.irq_flag = r.irq_flag & ~r.prdata[7:0];
		end
		// any mapped-register write other than the expected key breaks the unlock sequence
		if (wr_any) begin
			next_r.ul = dewg_pkg::UL_IDLE; // [RULE3]
			if (paddr == dewg_pkg::OFS_UNLOCK) begin
				if (pwdata[7:0] == dewg_pkg::UNLOCK_KEY1) begin
					next_r.ul = dewg_pkg::UL_KEY1;
				end else if (pwdata[7:0] == dewg_pkg::UNLOCK_KEY2 &&
					r.ul == dewg_pkg::UL_KEY1) begin
					next_r.ul = dewg_pkg::UL_ARMED;
				end
			end
		end
		// register writes; addr_lo and data_lo are frozen while a write runs
		if (wr_any) begin
			case (paddr)
				dewg_pkg::OFS_CONTROL: begin
					next_r.pgm_sel = pwdata[dewg_pkg::CTL_PGM];
					next_r.werr = pwdata[dewg_pkg::CTL_WERR];
					next_r.write_enable_bit = pwdata[dewg_pkg::CTL_WRITE_ENABLE_BIT];
					if (pwdata[dewg_pkg::CTL_RD] && r.ws == dewg_pkg::WS_IDLE &&
						!pwdata[dewg_pkg::CTL_PGM]) begin
						next_r.data_lo = r.mem[r.addr_lo];
						next_r.data_hi = dewg_pkg::RESET_BYTE;
					end
				end
				dewg_pkg::OFS_ADDR_LO: begin
					if (r.ws == dewg_pkg::WS_IDLE) begin
						next_r.addr_lo = pwdata[7:0];
					end
				end
				dewg_pkg::OFS_ADDR_HI: begin
					next_r.addr_hi = pwdata[7:0] & dewg_pkg::ADDRH_MASK; // [RULE11]
				end
				dewg_pkg::OFS_DATA_LO: begin
					if (r.ws == dewg_pkg::WS_IDLE) begin
						next_r.data_lo = pwdata[7:0];
					end
				end
				dewg_pkg::OFS_DATA_HI: begin
					next_r.data_hi = pwdata[7:0] & dewg_pkg::DATAH_MASK; // [RULE11]
				end
				dewg_pkg::OFS_IRQ_EN: begin
					next_r.irq_en = pwdata[7:0] & dewg_pkg::IRQ_MASK;
				end
				default: begin
				end
			endcase
		end
		// a refused start is reported, and wins over a software clear
		if (start_try && !start_ok) begin
			next_r.werr = 1'b1; // [RULE3]
		end
		if (start_ok) begin
			next_r.wr = 1'b1;
			next_r.ws = dewg_pkg::WS_BUSY;
			next_r.wcnt = dewg_pkg::WCNT_ZERO;
		end
		// array programming; data_lo is left holding the written byte
		if (r.ws == dewg_pkg::WS_BUSY) begin
			next_r.wcnt = r.wcnt + dewg_pkg::WCNT_ONE;
			if (w_done) begin
				next_r.mem[r.addr_lo] = r.data_lo; // [RULE9]
				next_r.wr = 1'b0;
				next_r.ws = dewg_pkg::WS_IDLE;
				next_r.irq_flag[dewg_pkg::IRQ_BIT] = 1'b1; // [RULE12]
			end
		end
		// programming path: refused outright while data memory is protected
		if (ext_go) begin
			next_r.x_ack = 1'b1;
			next_r.x_denied = prot; // [RULE6]
			next_r.x_rdata = dewg_pkg::RESET_BYTE;
			if (!prot) begin
				if (r.we_s[1]) begin
					next_r.mem[r.xa1] = r.xd1;
				end else begin
					next_r.x_rdata = r.mem[r.xa1];
				end
			end
		end
		next_r.irq = |(next_r.irq_flag & next_r.irq_en); // [RULE12]
	end

	// ********************************************
	// registers
	// ********************************************
	// the array resets to erased here; a real cell array would not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.ul <= dewg_pkg::UL_IDLE;
			r.ws <= dewg_pkg::WS_IDLE;
			r.write_enable_bit <= 1'b0; // [RULE1]
			r.prot_s <= 2'h0;
			r.mem <= {256{dewg_pkg::ERASED_BYTE}};
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq = r.irq;
	assign ext_prog_rdata = r.x_rdata;
	assign ext_prog_denied = r.x_denied;
	assign ext_prog_ack = r.x_ack;

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_start;
		(r.ws == dewg_pkg::WS_IDLE) ##1 (r.ws == dewg_pkg::WS_BUSY);
	endsequence

	property p_write_enable_bit_src;
		$rose(r.write_enable_bit) |-> $past(wr_ctl);
	endproperty
	a_write_enable_bit_src: assert property (p_write_enable_bit_src) // [RULE1]
		else $error("write enable rose without a control write");

	property p_pwrt_block;
		(pwrt_busy && start_try) |=> (r.ws == dewg_pkg::WS_IDLE) && r.werr;
	endproperty
	a_pwrt_block: assert property (p_pwrt_block) // [RULE2]
		else $error("write started during power-up timer");

	property p_start_cond;
		s_start |-> ($past(r.ul) == dewg_pkg::UL_ARMED) && $past(r.write_enable_bit);
	endproperty
	a_start_cond: assert property (p_start_cond) // [RULE3]
		else $error("write started without unlock and enable");

	property p_busy_len;
		s_start |-> (r.ws == dewg_pkg::WS_BUSY)[*8] ##1
			(r.ws == dewg_pkg::WS_IDLE) && !r.wr;
	endproperty
	a_busy_len: assert property (p_busy_len) // [RULE3]
		else $error("array write length wrong");

	property p_unprot_allow;
		(ext_go && r.prot_s[1]) |=> ext_prog_ack && !ext_prog_denied;
	endproperty
	a_unprot_allow: assert property (p_unprot_allow) // [RULE5]
		else $error("unprotected access was denied");

	property p_prot_deny;
		(ext_go && !r.prot_s[1]) |=> ext_prog_ack && ext_prog_denied &&
			(ext_prog_rdata == dewg_pkg::RESET_BYTE);
	endproperty
	a_prot_deny: assert property (p_prot_deny) // [RULE6]
		else $error("protected access was not denied");

	property p_data_hold;
		w_done |=> (r.data_lo == $past(r.data_lo)) &&
			(r.mem[$past(r.addr_lo)] == $past(r.data_lo));
	endproperty
	a_data_hold: assert property (p_data_hold) // [RULE9]
		else $error("data register lost the written value");

	property p_unimpl;
		(xfer && !pwrite && paddr == dewg_pkg::OFS_CONTROL) |->
			((prdata[7:0] & ~dewg_pkg::CTL_MASK) == dewg_pkg::RESET_BYTE) &&
			(prdata[31:8] == dewg_pkg::PRDATA_PAD);
	endproperty
	a_unimpl: assert property (p_unimpl) // [RULE11]
		else $error("unimplemented control bits read nonzero");

	property p_irq;
		(w_done && r.irq_en[dewg_pkg::IRQ_BIT]) |=>
			r.irq_flag[dewg_pkg::IRQ_BIT] && irq;
	endproperty
	a_irq: assert property (p_irq) // [RULE12]
		else $error("write done did not raise the interrupt");

endmodule : dewg_guard

// file: verif/dewg_core.sv
`timescale 1ns/1ps
// ********************************************
// core side apb master model
// ********************************************
module dewg_core (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// one transfer; the leading edge keeps two calls from colliding
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err,
		output logic tmo);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		tmo = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released bus must not show stale data
	endtask : xfer
endmodule : dewg_core

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	typedef struct {
		string nm;
		logic [32:0] v;
	} dewg_exp_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, ep_a, ep_d, ep_rd, a, d;
	logic [31:0] pwdata, prdata, rd;
	logic cfg, ep_req, ep_w, ep_den, ep_ack, err, tmo;
	dewg_exp_t q[$];
	dewg_exp_t e;
	int n_errors, num_checks;
	localparam int PW = 24;

	// ********************************************
	// design, core model and clock
	// ********************************************
	dewg_guard #(.PWRT_CYCLES(PW)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .data_protect_config_bit(cfg),
		.ext_prog_req(ep_req), .ext_prog_write(ep_w),
		.ext_prog_addr(ep_a), .ext_prog_wdata(ep_d),
		.ext_prog_rdata(ep_rd), .ext_prog_denied(ep_den),
		.ext_prog_ack(ep_ack));
	dewg_core core (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	always #10 pclk = ~pclk;

	// ********************************************
	// checking and closing
	// ********************************************
	task automatic check(input string nm, input logic [32:0] s, x);
		num_checks++;
		if (s !== x) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, x, s);
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	task automatic hang(input logic t);
		if (t) begin
			n_errors++;
			close_out();
		end
	endtask : hang
	// every completed read takes the oldest note off the queue
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (q.size() == 0) begin
				check("queue", 33'h0_0000_0000, 33'h0_0000_0001);
			end else begin
				e = q.pop_front();
				check(e.nm, {pslverr, prdata}, e.v);
			end
		end
	end

	// ********************************************
	// stimulus tasks
	// ********************************************
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		core.xfer(1'b1, ad, {dewg_pkg::PRDATA_PAD, dt}, rd, err, tmo);
		hang(tmo);
	endtask : wr
	task automatic rdc(input logic [7:0] ad, x, input logic er,
		input string nm);
		q.push_back('{nm, {er, dewg_pkg::PRDATA_PAD, x}});
		core.xfer(1'b0, ad, 32'h0000_0000, rd, err, tmo);
		hang(tmo);
	endtask : rdc
	task automatic unlock_start(input logic brk);
		wr(dewg_pkg::OFS_UNLOCK, dewg_pkg::UNLOCK_KEY1);
		if (brk) begin
			wr(dewg_pkg::OFS_ADDR_LO, a);
		end
		wr(dewg_pkg::OFS_UNLOCK, dewg_pkg::UNLOCK_KEY2);
		wr(dewg_pkg::OFS_CONTROL, 8'h06);
	endtask : unlock_start
	// programming path access; request held until the ack pulse
	task automatic ep(input logic w, input logic [7:0] ad, dt,
		input logic dx, input logic [7:0] rx);
		int n;
		n = 0;
		@(posedge pclk);
		ep_w <= w;
		ep_a <= ad;
		ep_d <= dt;
		repeat (4) @(posedge pclk);
		ep_req <= 1'b1;
		do begin
			@(negedge pclk);
			n++;
		end while (ep_ack !== 1'b1 && n < 20);
		hang(ep_ack !== 1'b1);
		check("ep denied", ep_den, dx);
		if (!w) check("ep rdata", ep_rd, rx);
		@(posedge pclk);
		ep_req <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : ep
	task automatic read_back(input logic [7:0] x);
		wr(dewg_pkg::OFS_CONTROL, 8'h01);
		rdc(dewg_pkg::OFS_DATA_LO, x, 1'b0, "array byte");
	endtask : read_back

	// ********************************************
	// main sequence
	// ********************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		cfg = 1'b1;
		ep_req = 1'b0;
		ep_w = 1'b0;
		ep_a = 8'h00;
		ep_d = 8'h00;
		n_errors = 0;
		num_checks = 0;
		void'($urandom(32'h0c1151d5));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// unlocked start inside the power-up interval is refused
		rdc(dewg_pkg::OFS_CONTROL, 8'h00, 1'b0, "ctl reset");
		wr(dewg_pkg::OFS_CONTROL, 8'h04);
		unlock_start(1'b0);
		rdc(dewg_pkg::OFS_CONTROL, 8'h0c, 1'b0, "ctl pwrt");
		repeat (PW) @(posedge pclk);
		read_back(dewg_pkg::ERASED_BYTE);
		$display("test power-up done");
		// reset values, unimplemented bits, unmapped place
		for (int i = 1; i < 8; i++) begin
			if (i != 4) rdc(8'(i * 4), 8'h00, 1'b0, "reset val");
		end
		rdc(8'h20, 8'h00, 1'b1, "unmapped");
		wr(8'h20, 8'h5a);
		check("wr slverr", err, 1'b1);
		wr(dewg_pkg::OFS_ADDR_HI, 8'hff);
		rdc(dewg_pkg::OFS_ADDR_HI, 8'h1f, 1'b0, "addr hi");
		wr(dewg_pkg::OFS_DATA_HI, 8'hff);
		rdc(dewg_pkg::OFS_DATA_HI, 8'h3f, 1'b0, "data hi");
		wr(dewg_pkg::OFS_CONTROL, 8'h78);
		rdc(dewg_pkg::OFS_CONTROL, 8'h08, 1'b0, "ctl bits");
		$display("test registers done");
		// starts lacking enable, lacking unlock, broken unlock
		a = 8'($urandom);
		wr(dewg_pkg::OFS_ADDR_LO, a);
		wr(dewg_pkg::OFS_DATA_LO, 8'($urandom));
		wr(dewg_pkg::OFS_CONTROL, 8'h00);
		unlock_start(1'b0);
		rdc(dewg_pkg::OFS_CONTROL, 8'h0c, 1'b0, "no enable");
		wr(dewg_pkg::OFS_CONTROL, 8'h04);
		wr(dewg_pkg::OFS_CONTROL, 8'h06);
		rdc(dewg_pkg::OFS_CONTROL, 8'h0c, 1'b0, "no unlock");
		wr(dewg_pkg::OFS_CONTROL, 8'h04);
		unlock_start(1'b1);
		rdc(dewg_pkg::OFS_CONTROL, 8'h0c, 1'b0, "broken");
		rdc(dewg_pkg::OFS_IRQ_FLAG, 8'h00, 1'b0, "no flag");
		read_back(dewg_pkg::ERASED_BYTE);
		$display("test refused done");
		// good writes, interrupt enabled then masked
		for (int k = 0; k < 2; k++) begin
			a = 8'($urandom);
			d = 8'($urandom);
			wr(dewg_pkg::OFS_IRQ_EN, (k == 0) ? dewg_pkg::IRQ_MASK : 8'h00);
			wr(dewg_pkg::OFS_ADDR_LO, a);
			wr(dewg_pkg::OFS_DATA_LO, d);
			wr(dewg_pkg::OFS_CONTROL, 8'h04);
			unlock_start(1'b0);
			repeat (12) @(posedge pclk);
			@(negedge pclk);
			check("irq", irq, k == 0);
			rdc(dewg_pkg::OFS_CONTROL, 8'h04, 1'b0, "ctl done");
			rdc(dewg_pkg::OFS_DATA_LO, d, 1'b0, "data kept");
			rdc(dewg_pkg::OFS_IRQ_FLAG, 8'h10, 1'b0, "flag");
			@(negedge pclk);
			check("irq clr", irq, 1'b0);
			rdc(dewg_pkg::OFS_IRQ_FLAG, 8'h00, 1'b0, "flag clr");
			read_back(d);
		end
		// refresh: rewrite the byte just read back with its own value
		wr(dewg_pkg::OFS_CONTROL, 8'h04);
		unlock_start(1'b0);
		repeat (12) @(posedge pclk);
		rdc(dewg_pkg::OFS_IRQ_FLAG, 8'h10, 1'b0, "refresh flag");
		read_back(d);
		$display("test write done");
		// programming path open, then protected
		ep(1'b0, a, 8'h00, 1'b0, d);
		ep(1'b1, a + 8'h01, ~d, 1'b0, 8'h00);
		ep(1'b0, a + 8'h01, 8'h00, 1'b0, ~d);
		@(posedge pclk);
		cfg <= 1'b0;
		ep(1'b0, a, 8'h00, 1'b1, 8'h00);
		ep(1'b1, a, ~d, 1'b1, 8'h00);
		// program memory starts stay refused, so protected data cannot leak
		wr(dewg_pkg::OFS_CONTROL, 8'h84);
		wr(dewg_pkg::OFS_UNLOCK, dewg_pkg::UNLOCK_KEY1);
		wr(dewg_pkg::OFS_UNLOCK, dewg_pkg::UNLOCK_KEY2);
		wr(dewg_pkg::OFS_CONTROL, 8'h86);
		rdc(dewg_pkg::OFS_CONTROL, 8'h8c, 1'b0, "pgm start");
		wr(dewg_pkg::OFS_ADDR_LO, a);
		read_back(d);
		$display("test protect done");
		close_out();
	end
endmodule : testbench
